/* logic/iras_slave.sv */
// Purpose: two-wire slave giving an external controller access to control registers
// Assumes: scl_i and sda_i already synchronous to core_clk_i; open-drain pins
// Notes: scl and sda are driven low only, with output enables high while driving
// Function
// - The block is only a slave and may hold the clock line low to gain access time.
// - Each write transfer sends the chip address and then one subaddress naming the register.
// - Only chip address 1000111 is answered, with the eighth bit one for read, zero for write.
// - Registers hold up to 16 bits, one wider than 8 bits moved as two bytes in one transaction.
// - Unimplemented upper bits are ignored on write and read back as zero.
// - Reset clears every control register to zero.
// - After reset a chosen set of registers is loaded with default values.
// - Only read-back registers return their written value; status registers are read-only.
// - Vertically latched registers take a written value only at the next vertical sync.
`timescale 1ns/10ps
`default_nettype none
module iras_slave (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic vsync_i,
   input wire logic [iras_pkg::IRAS_NREG*16-1:0] stat_i,
   output logic [iras_pkg::IRAS_NREG*16-1:0] ctrl_o
);

   iras_acc_if acc ();

   iras_reg_bank u_bank (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .vsync_i(vsync_i),
      .stat_i(stat_i),
      .acc(acc),
      .ctrl_o(ctrl_o)
   );

   iras_pkg::iras_state_e state;
   logic scl_q;
   logic sda_q;
   logic [2:0] bit_cnt;
   logic byte_full;
   logic [7:0] shift;
   logic [7:0] tx;
   logic [7:0] hold_hi;
   logic [7:0] sub_q;
   logic [1:0] byte_idx;
   logic rw_q;
   logic [3:0] stretch;
   logic drive_lvl;

   // line events, both lines sampled once per core clock
   wire logic start_det = scl_i && scl_q && sda_q && !sda_i;
   wire logic stop_det = scl_i && scl_q && !sda_q && sda_i;
   wire logic scl_rise = scl_i && !scl_q;
   wire logic scl_fall = !scl_i && scl_q;
   wire logic rx_state = (state == iras_pkg::IRAS_ST_ADDR) || (state == iras_pkg::IRAS_ST_SUB)
                         || (state == iras_pkg::IRAS_ST_WDATA);
   wire logic byte_end = scl_fall && byte_full;
   wire logic addr_hit = (shift[7:1] == iras_pkg::IRAS_DEV_ADDR);

   // byte order on the wire: high byte first for wide registers
   wire logic [7:0] rd_hi = (byte_idx == 2'd0) ? acc.rdata[15:8] :
                            (byte_idx == 2'd1) ? acc.rdata[7:0] : 8'h00;
   wire logic [7:0] rd_lo = (byte_idx == 2'd0) ? acc.rdata[7:0] : 8'h00;
   wire logic [7:0] rd_byte = !acc.hit ? 8'h00 : acc.wide ? rd_hi : rd_lo;
   wire logic last_wr = acc.wide ? (byte_idx == 2'd1) : (byte_idx == 2'd0);

   // a register is written once its whole byte count has arrived
   assign acc.wr_stb = (state == iras_pkg::IRAS_ST_WDATA) && byte_end && last_wr;
   assign acc.wdata = acc.wide ? {hold_hi, shift} : {8'h00, shift};
   assign acc.sub = sub_q;

   // open-drain: level output is always low, only the enables move
   assign scl_o = drive_lvl;
   assign sda_o = drive_lvl;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         drive_lvl <= 1'b0;
         scl_oe_o <= 1'b0;
      end else begin
         drive_lvl <= 1'b0;
         // hold the clock low while a register access settles
         scl_oe_o <= (stretch != 4'h0);
      end
   end

   // bit sampler: receive shifts on rising clock, transmit counts rises
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state <= iras_pkg::IRAS_ST_IDLE;
         bit_cnt <= 3'h0;
         byte_full <= 1'b0;
         shift <= 8'h00;
         tx <= 8'h00;
         hold_hi <= 8'h00;
         sub_q <= 8'h00;
         byte_idx <= 2'h0;
         rw_q <= 1'b0;
         stretch <= 4'h0;
         sda_oe_o <= 1'b0;
      end else begin
         if (stretch != 4'h0) begin
            stretch <= stretch - 4'h1;
         end
         if (start_det) begin
            // repeated start keeps the subaddress for the read that follows
            state <= iras_pkg::IRAS_ST_ADDR;
            bit_cnt <= 3'h0;
            byte_full <= 1'b0;
            sda_oe_o <= 1'b0;
         end else if (stop_det) begin
            state <= iras_pkg::IRAS_ST_IDLE;
            byte_full <= 1'b0;
            sda_oe_o <= 1'b0;
         end else begin
            if (scl_rise && (rx_state || state == iras_pkg::IRAS_ST_RDATA)) begin
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) begin
                  byte_full <= 1'b1;
               end
               if (rx_state) begin
                  shift <= {shift[6:0], sda_i};
               end
            end
            unique case (state)
               iras_pkg::IRAS_ST_IDLE: begin
               end
               iras_pkg::IRAS_ST_ADDR: begin
                  if (byte_end) begin
                     byte_full <= 1'b0;
                     if (addr_hit) begin
                        rw_q <= shift[0];
                        byte_idx <= 2'h0;
                        sda_oe_o <= 1'b1;
                        stretch <= iras_pkg::IRAS_ACCESS_CYC;
                        state <= iras_pkg::IRAS_ST_AACK;
                     end else begin
                        // other chip addressed: stay off the bus until next start
                        state <= iras_pkg::IRAS_ST_IDLE;
                     end
                  end
               end
               iras_pkg::IRAS_ST_AACK: begin
                  if (scl_fall) begin
                     bit_cnt <= 3'h0;
                     if (rw_q) begin
                        tx <= rd_byte;
                        sda_oe_o <= !rd_byte[7];
                        state <= iras_pkg::IRAS_ST_RDATA;
                     end else begin
                        sda_oe_o <= 1'b0;
                        state <= iras_pkg::IRAS_ST_SUB;
                     end
                  end
               end
               iras_pkg::IRAS_ST_SUB: begin
                  if (byte_end) begin
                     byte_full <= 1'b0;
                     sub_q <= shift;
                     byte_idx <= 2'h0;
                     sda_oe_o <= 1'b1;
                     stretch <= iras_pkg::IRAS_ACCESS_CYC;
                     state <= iras_pkg::IRAS_ST_WACK;
                  end
               end
               iras_pkg::IRAS_ST_WACK: begin
                  if (scl_fall) begin
                     sda_oe_o <= 1'b0;
                     bit_cnt <= 3'h0;
                     state <= iras_pkg::IRAS_ST_WDATA;
                  end
               end
               iras_pkg::IRAS_ST_WDATA: begin
                  if (byte_end) begin
                     byte_full <= 1'b0;
                     if (acc.wide && byte_idx == 2'd0) begin
                        hold_hi <= shift;
                     end
                     // surplus bytes are acknowledged and dropped
                     if (byte_idx != 2'd2) begin
                        byte_idx <= byte_idx + 2'h1;
                     end
                     sda_oe_o <= 1'b1;
                     stretch <= iras_pkg::IRAS_ACCESS_CYC;
                     state <= iras_pkg::IRAS_ST_WACK;
                  end
               end
               iras_pkg::IRAS_ST_RDATA: begin
                  if (byte_end) begin
                     byte_full <= 1'b0;
                     sda_oe_o <= 1'b0;
                     if (byte_idx != 2'd2) begin
                        byte_idx <= byte_idx + 2'h1;
                     end
                     state <= iras_pkg::IRAS_ST_RACK;
                  end else if (scl_fall) begin
                     tx <= {tx[6:0], 1'b0};
                     sda_oe_o <= !tx[6];
                  end
               end
               iras_pkg::IRAS_ST_RACK: begin
                  if (scl_rise) begin
                     // master not-acknowledge ends the read
                     state <= sda_i ? iras_pkg::IRAS_ST_IDLE : iras_pkg::IRAS_ST_RNEXT;
                  end
               end
               iras_pkg::IRAS_ST_RNEXT: begin
                  if (scl_fall) begin
                     tx <= rd_byte;
                     sda_oe_o <= !rd_byte[7];
                     bit_cnt <= 3'h0;
                     stretch <= iras_pkg::IRAS_ACCESS_CYC;
                     state <= iras_pkg::IRAS_ST_RDATA;
                  end
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* logic/iras_pkg.sv */
// Purpose: shared constants and types of the two-wire register access slave
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes: register map entries are indexed 0..IRAS_NREG-1
package iras_pkg;

   localparam logic [6:0] IRAS_DEV_ADDR = 7'h47;
   localparam int IRAS_NREG = 8;
   localparam int IRAS_DW = 16;
   localparam int IRAS_IW = 3;

   typedef enum logic [1:0] {
      IRAS_MODE_W = 2'b00,
      IRAS_MODE_WR = 2'b01,
      IRAS_MODE_R = 2'b10
   } iras_mode_e;

   typedef enum logic [3:0] {
      IRAS_ST_IDLE = 4'h0,
      IRAS_ST_ADDR = 4'h1,
      IRAS_ST_AACK = 4'h2,
      IRAS_ST_SUB = 4'h3,
      IRAS_ST_WACK = 4'h4,
      IRAS_ST_WDATA = 4'h5,
      IRAS_ST_RDATA = 4'h6,
      IRAS_ST_RACK = 4'h7,
      IRAS_ST_RNEXT = 4'h8
   } iras_state_e;

   // register map: subaddress, implemented bits, mode, vsync latch, init load, default
   localparam logic [7:0] IRAS_REG_SUB [IRAS_NREG] =
      '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h22, 8'h23};
   localparam int IRAS_REG_BITS [IRAS_NREG] = '{8, 16, 9, 12, 8, 16, 8, 11};
   localparam iras_mode_e IRAS_REG_MODE [IRAS_NREG] =
      '{IRAS_MODE_WR, IRAS_MODE_WR, IRAS_MODE_W, IRAS_MODE_WR,
        IRAS_MODE_R, IRAS_MODE_R, IRAS_MODE_W, IRAS_MODE_WR};
   localparam logic IRAS_REG_VLAT [IRAS_NREG] =
      '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   localparam logic IRAS_REG_INIT [IRAS_NREG] =
      '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   localparam logic [15:0] IRAS_REG_DEF [IRAS_NREG] =
      '{16'h0000, 16'h0123, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h005A, 16'h0200};

   // clock stretch after each acknowledged byte, a least time rounded up to cycles
   localparam int IRAS_CLK_PS = 5000;
   localparam int IRAS_ACCESS_NS = 20;
   localparam logic [3:0] IRAS_ACCESS_CYC =
      4'((IRAS_ACCESS_NS * 1000 + IRAS_CLK_PS - 1) / IRAS_CLK_PS);

   function automatic logic [15:0] iras_mask(input int bits);
      iras_mask = 16'((32'h1 << bits) - 32'h1);
   endfunction

endpackage

/* logic/iras_acc_if.sv */
// Purpose: register access path between protocol engine and register bank
// Assumes: all signals in the core_clk_i domain
// Notes: wr_stb is a one-cycle pulse; rdata, hit and wide decode sub combinationally
`timescale 1ns/10ps
`default_nettype none
interface iras_acc_if;
   logic wr_stb;
   logic [7:0] sub;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic hit;
   logic wide;
   modport eng (output wr_stb, output sub, output wdata,
                input rdata, input hit, input wide);
   modport bank (input wr_stb, input sub, input wdata,
                 output rdata, output hit, output wide);
endinterface
`default_nettype wire

/* logic/iras_reg_bank.sv */
// Purpose: control and status register store behind the two-wire slave
// Assumes: vsync_i is a one-cycle pulse per vertical sync
// Notes: ctrl_o carries the effective (possibly vsync-latched) values
`timescale 1ns/10ps
`default_nettype none
module iras_reg_bank (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic vsync_i,
   input wire logic [iras_pkg::IRAS_NREG*16-1:0] stat_i,
   iras_acc_if.bank acc,
   output logic [iras_pkg::IRAS_NREG*16-1:0] ctrl_o
);

   function automatic logic [iras_pkg::IRAS_IW-1:0] iras_find(input logic [7:0] s);
      iras_find = '0;
      for (int k = 0; k < iras_pkg::IRAS_NREG; k++) begin
         if (iras_pkg::IRAS_REG_SUB[k] == s) begin
            iras_find = iras_pkg::IRAS_IW'(k);
         end
      end
   endfunction

   logic init_pend;
   logic [15:0] rd_vec [iras_pkg::IRAS_NREG];
   logic [iras_pkg::IRAS_NREG-1:0] hit_vec;
   logic [iras_pkg::IRAS_NREG-1:0] wide_vec;
   wire logic [iras_pkg::IRAS_IW-1:0] sel = iras_find(acc.sub);

   // one-shot default load right after reset release
   always_ff @(posedge core_clk_i) begin
      init_pend <= srst_i;
   end

   genvar i;
   generate
      for (i = 0; i < iras_pkg::IRAS_NREG; i++) begin : g_reg
         localparam logic [15:0] MSK = iras_pkg::iras_mask(iras_pkg::IRAS_REG_BITS[i]);
         logic [15:0] shadow;
         logic [15:0] active;
         wire logic wr_me = acc.wr_stb && hit_vec[i]
                            && (iras_pkg::IRAS_REG_MODE[i] != iras_pkg::IRAS_MODE_R);
         assign hit_vec[i] = (iras_pkg::IRAS_REG_SUB[i] == acc.sub);
         assign wide_vec[i] = (iras_pkg::IRAS_REG_BITS[i] > 8);
         always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
               shadow <= 16'h0000;
               active <= 16'h0000;
            end else if (init_pend && iras_pkg::IRAS_REG_INIT[i]) begin
               shadow <= iras_pkg::IRAS_REG_DEF[i] & MSK;
               active <= iras_pkg::IRAS_REG_DEF[i] & MSK;
            end else begin
               if (wr_me) begin
                  shadow <= acc.wdata & MSK;
               end
               if (iras_pkg::IRAS_REG_VLAT[i]) begin
                  // new value reaches the core only at vertical sync
                  if (vsync_i) begin
                     active <= shadow;
                  end
               end else if (wr_me) begin
                  active <= acc.wdata & MSK;
               end
            end
         end
         // write-only registers read zero, status reads come from the core
         if (iras_pkg::IRAS_REG_MODE[i] == iras_pkg::IRAS_MODE_WR) begin : g_wr
            assign rd_vec[i] = shadow;
         end else if (iras_pkg::IRAS_REG_MODE[i] == iras_pkg::IRAS_MODE_R) begin : g_r
            assign rd_vec[i] = stat_i[i*16 +: 16] & MSK;
         end else begin : g_w
            assign rd_vec[i] = 16'h0000;
         end
         assign ctrl_o[i*16 +: 16] = active;
      end
   endgenerate

   assign acc.hit = |hit_vec;
   assign acc.wide = acc.hit && wide_vec[sel];
   assign acc.rdata = acc.hit ? rd_vec[sel] : 16'h0000;

endmodule
`default_nettype wire

/* tb/iras_slave_sva.sv */
// Purpose: port-level checks of the two-wire register slave
// Assumes: one clock, srst_i synchronous active high
// Notes: stretch length of 4 cycles is the designer's choice
`timescale 1ns/10ps
`default_nettype none
module iras_slave_sva (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_o,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic vsync_i,
   input wire logic [iras_pkg::IRAS_NREG*16-1:0] stat_i,
   input wire logic [iras_pkg::IRAS_NREG*16-1:0] ctrl_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_hold;
      scl_oe_o [*4] ##1 !scl_oe_o;
   endsequence
   AST_DRIVE_LOW: assert property ((scl_oe_o |-> !scl_o) and (sda_oe_o |-> !sda_o))
      else $error("open-drain pin driven high");
   AST_STRETCH_LEN: assert property ($rose(scl_oe_o) |-> s_hold)
      else $error("clock stretch length wrong");
   AST_STRETCH_START: assert property ($rose(scl_oe_o) |-> !$past(scl_i) && !$past(scl_i, 2))
      else $error("stretch began while clock high");
   AST_SDA_MOVE: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line moved while clock high");
   AST_RST_CLEAR: assert property (disable iff (1'b0)
      srst_i |=> ctrl_o == '0 && !scl_oe_o && !sda_oe_o)
      else $error("reset did not clear");
   AST_INIT_LOAD: assert property ($fell(srst_i) |-> ##2
      ctrl_o[16+:16] == iras_pkg::IRAS_REG_DEF[1] && ctrl_o[32+:16] == iras_pkg::IRAS_REG_DEF[2]
      && ctrl_o[96+:16] == iras_pkg::IRAS_REG_DEF[6]
      && ctrl_o[112+:16] == iras_pkg::IRAS_REG_DEF[7])
      else $error("defaults not loaded");
   AST_UNIMP_ZERO: assert property (ctrl_o[8+:8] == '0 && ctrl_o[41+:7] == '0
      && ctrl_o[60+:4] == '0 && ctrl_o[104+:8] == '0 && ctrl_o[123+:5] == '0)
      else $error("unimplemented bits set");
   AST_VLAT: assert property ($changed({ctrl_o[16+:16], ctrl_o[48+:16], ctrl_o[96+:16]})
      |-> $past(vsync_i) || $past(srst_i, 2) || $past(srst_i, 3))
      else $error("latched register moved without vsync");
   AST_WR_AT_BYTE: assert property ($changed(ctrl_o[15:0]) |-> !$past(scl_i))
      else $error("register written mid-bit");
endmodule
bind iras_slave iras_slave_sva u_sva (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl_i),
   .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .vsync_i(vsync_i), .stat_i(stat_i), .ctrl_o(ctrl_o));
`default_nettype wire

/* tb/iras_host_model.sv */
// Purpose: two-wire bus master standing in for the system controller
// Assumes: pull-ups on both lines, wired-AND resolved in tb
// Notes: waits out clock stretching, bounded to 200 cycles
`timescale 1ns/10ps
`default_nettype none
module iras_host_model (
   input wire logic core_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output var logic scl_o,
   output var logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic hw(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // clock synchronization: high phase starts only once the slave lets go
   task automatic up();
      int k;
      k = 0;
      scl_o <= 1'b1;
      hw(1);
      while (!scl_i && k < 200) begin
         hw(1);
         k++;
      end
      hw(4);
   endtask
   // low phase shorter than the slave's stretch, so the wait in up() is really taken
   task automatic bit_io(input logic b, output logic r);
      sda_o <= b;
      hw(2);
      up();
      r = sda_i;
      scl_o <= 1'b0;
      hw(2);
   endtask
   task automatic start();
      sda_o <= 1'b1;
      hw(2);
      up();
      sda_o <= 1'b0;
      hw(4);
      scl_o <= 1'b0;
      hw(4);
   endtask
   task automatic stop();
      sda_o <= 1'b0;
      hw(4);
      up();
      sda_o <= 1'b1;
      hw(8);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, r);
   endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the two-wire register slave
// Assumes: host model drives the bus, bench drives vsync and status
// Notes: default expectations come from the package register map, the other tests use literal values
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic core_clk_i, srst_i, vsync_i, scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl, m_sda;
   logic [iras_pkg::IRAS_NREG*16-1:0] stat_i, ctrl_o;
   wire scl_w, sda_w;
   int fail_count, n_tests;
   localparam logic [7:0] dev_wr = {iras_pkg::IRAS_DEV_ADDR, 1'b0};
   localparam logic [7:0] dev_rd = {iras_pkg::IRAS_DEV_ADDR, 1'b1};
   assign scl_w = m_scl & (scl_oe_o ? scl_o : 1'b1);
   assign sda_w = m_sda & (sda_oe_o ? sda_o : 1'b1);
   iras_slave DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .vsync_i(vsync_i), .stat_i(stat_i), .ctrl_o(ctrl_o));
   iras_host_model HOST (.core_clk_i(core_clk_i), .scl_i(scl_w), .sda_i(sda_w),
      .scl_o(m_scl), .sda_o(m_sda));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] sub, input logic two, input logic [15:0] d);
      logic a, ok;
      HOST.start();
      HOST.wbyte(dev_wr, ok);
      HOST.wbyte(sub, a);
      ok &= a;
      if (two) begin
         HOST.wbyte(d[15:8], a);
         ok &= a;
      end
      HOST.wbyte(d[7:0], a);
      ok &= a;
      HOST.stop();
      chk({15'h0000, ok}, 16'h0001);
   endtask
   task automatic rd_reg(input logic [7:0] sub, input logic two, input logic [15:0] exp);
      logic a;
      logic [7:0] hi, lo;
      hi = 8'h00;
      HOST.start();
      HOST.wbyte(dev_wr, a);
      HOST.wbyte(sub, a);
      HOST.start();
      HOST.wbyte(dev_rd, a);
      if (two) begin
         HOST.rbyte(1'b0, hi);
      end
      HOST.rbyte(1'b1, lo);
      HOST.stop();
      chk({hi, lo}, exp);
   endtask
   task automatic t_defaults();
      for (int i = 0; i < iras_pkg::IRAS_NREG; i++) begin
         chk(ctrl_o[i*16+:16], iras_pkg::IRAS_REG_INIT[i] ? iras_pkg::IRAS_REG_DEF[i] : 16'h0000);
      end
      $display("test defaults done");
   endtask
   task automatic t_wr8();
      wr_reg(8'h10, 1'b0, 16'h00A5);
      chk(ctrl_o[15:0], 16'h00A5);
      rd_reg(8'h10, 1'b0, 16'h00A5);
      $display("test wr8 done");
   endtask
   task automatic t_vlat();
      wr_reg(8'h11, 1'b1, 16'h1234);
      chk(ctrl_o[31:16], 16'h0123);
      @(posedge core_clk_i) vsync_i <= 1'b1;
      @(posedge core_clk_i) vsync_i <= 1'b0;
      @(posedge core_clk_i);
      chk(ctrl_o[31:16], 16'h1234);
      rd_reg(8'h11, 1'b1, 16'h1234);
      $display("test vlat done");
   endtask
   task automatic t_mask();
      wr_reg(8'h12, 1'b1, 16'hFFFF);
      chk(ctrl_o[47:32], 16'h01FF);
      rd_reg(8'h12, 1'b1, 16'h0000);
      $display("test mask done");
   endtask
   task automatic t_status();
      @(posedge core_clk_i) stat_i <= {32'h0, 16'hBEEF, 16'h12C3, 64'h0};
      rd_reg(8'h21, 1'b1, 16'hBEEF);
      rd_reg(8'h20, 1'b0, 16'h00C3);
      wr_reg(8'h21, 1'b1, 16'h5555);
      rd_reg(8'h21, 1'b1, 16'hBEEF);
      $display("test status done");
   endtask
   task automatic t_badaddr();
      logic a;
      HOST.start();
      HOST.wbyte({7'h46, 1'b0}, a);
      HOST.stop();
      chk({15'h0000, a}, 16'h0000);
      $display("test badaddr done");
   endtask
   task automatic t_rst2();
      @(posedge core_clk_i) srst_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      srst_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      t_defaults();
      $display("test rst2 done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   initial begin
      fail_count = 0;
      n_tests = 0;
      srst_i = 1'b1;
      vsync_i = 1'b0;
      stat_i = '0;
      repeat (5) @(posedge core_clk_i);
      srst_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      t_defaults();
      t_wr8();
      t_vlat();
      t_mask();
      t_status();
      t_badaddr();
      t_rst2();
      stop_test();
   end
   // whole run needs about 4000 cycles
   initial begin
      repeat (60000) @(posedge core_clk_i);
      fail_count++;
      stop_test();
   end
endmodule
`default_nettype wire
